// *** core/smtc_core.sv ***
// Serial master transfer control: AHB-Lite registers, FIFOs, shifter.
// Assumes rxd arrives asynchronously; one clock domain otherwise.
//
// Overview of operation
// RULE1 - start needs enable, tx data, selected target
// RULE2 - busy flag set while transfer runs
// RULE3 - busy only once shifting starts on edge
// RULE4 - software waits before polling busy
// RULE5 - tx modes end when tx FIFO empty
// RULE6 - tx threshold raises early empty request
// RULE7 - tx DMA request at tx DMA level
// RULE8 - software keeps tx FIFO fed
// RULE9 - receive-only pops once, txd held constant
// RULE10 - receive-only ends after count plus one
// RULE11 - eeprom sends command, then stores reads
// RULE12 - eeprom read unsupported with SSP framing
// RULE13 - rx threshold and rx DMA requests
// RULE14 - software disables before reconfiguring
// RULE15 - start waits for any target enable
// RULE16 - software refills and drains FIFOs
// RULE17 - software matches clock polarity to target
// RULE18 - three-wire starts on control word, target
// RULE19 - three-wire transmit ends when tx empty
// RULE20 - nonsequential receive ends when tx empty
// RULE21 - sequential receive ends after count plus one
// RULE22 - handshake waits for slave ready
// RULE23 - direction zero receives, one transmits
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "smtc_regs.svh"
module smtc_core (
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire smtc_pkg::smtc_ahb_in_t ahbIn,
	output smtc_pkg::smtc_ahb_out_t ahbOut,
	input wire logic rxdPin,
	output smtc_pkg::smtc_ser_t serOut,
	output smtc_pkg::smtc_req_t reqOut
);
	import smtc_pkg::*;

	logic [0:0] block_enable_reg;
	logic [15:0] main_control_reg;
	logic [15:0] frame_count_reg;
	logic [2:0] three_wire_control_reg;
	logic [3:0] target_enable_reg;
	logic [15:0] clock_divider_reg;
	logic [2:0] tx_threshold_level;
	logic [2:0] rx_threshold_level;
	logic [2:0] tx_dma_level;
	logic [2:0] rx_dma_level;
	logic [1:0] dmaCtl_reg;
	logic dWr_reg;
	logic [7:0] dAddr_reg;
	logic [7:0] txMem [8];
	logic [7:0] rxMem [8];
	logic [2:0] txWr_reg, txRd_reg, rxWr_reg, rxRd_reg;
	logic [3:0] txCount_reg, rxCount_reg;
	logic rxdMeta_reg, rxdSync_reg;
	logic [14:0] divCnt_reg;
	smtc_state_t state_reg;
	logic [7:0] shiftTx_reg, shiftRx_reg, rxData_reg;
	logic [2:0] bitCnt_reg;
	logic half_reg, mwInData_reg, eeRx_reg, hsWait_reg;
	logic pendPop_reg, pendConst_reg, txPop_reg, rxPush_reg;
	logic [15:0] rxCnt_reg;
	logic busy_reg;
	smtc_kind_t kind;
	smtc_fmt_t fmt;
	logic cpol, mwSeq, mwDir, handshake_enable_bit, tick, txLeft, rxHit;
	logic capture, goPop, goConst, addrPh, busWrFifo, busRdFifo;
	logic tx_fifo_empty_flag, txeLvl, rxfLvl;

	assign fmt = smtc_fmt_t'(main_control_reg[`SMTC_CTL_FMT_LSB +: 2]);
	assign cpol = main_control_reg[`SMTC_CTL_CPOL_BIT];
	assign mwSeq = three_wire_control_reg[`SMTC_MW_SEQ_BIT];
	assign mwDir = three_wire_control_reg[`SMTC_MW_DIR_BIT];
	assign handshake_enable_bit = three_wire_control_reg[`SMTC_MW_HS_BIT];
	assign txLeft = txCount_reg != 4'h0;
	assign tx_fifo_empty_flag = !txLeft;
	assign rxHit = rxCnt_reg == frame_count_reg;
	assign txeLvl = txCount_reg <= {1'b0, tx_threshold_level};
	assign rxfLvl = rxCount_reg > {1'b0, rx_threshold_level};

	// RULE12 eeprom under SSP
	// Eeprom read under SSP framing falls back to transmit and receive.
	always_comb begin
		kind = smtc_kind_t'(main_control_reg[`SMTC_CTL_KIND_LSB +: 2]);
		if (fmt == FMT_SSP && kind == KIND_EEPROM)
			kind = KIND_TXRX;
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY
	assign addrPh = ahbIn.hsel && ahbIn.htrans[1] && ahbIn.hready;
	assign busRdFifo = ce && addrPh && !ahbIn.hwrite &&
		ahbIn.haddr[7:0] == `SMTC_OFF_FIFO && rxCount_reg != 4'h0;
	assign busWrFifo = ce && dWr_reg && dAddr_reg == `SMTC_OFF_FIFO &&
		block_enable_reg[0] && txCount_reg != `SMTC_FIFO_FULL;

	always_ff @(posedge clock) begin
		if (srst) begin
			dWr_reg <= 1'b0;
			dAddr_reg <= 8'h00;
			ahbOut <= '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};
		end else if (ce) begin
			dWr_reg <= addrPh && ahbIn.hwrite;
			dAddr_reg <= ahbIn.haddr[7:0];
			ahbOut.hrdata <= 32'h0;
			if (addrPh && !ahbIn.hwrite) begin
				case (ahbIn.haddr[7:0])
				`SMTC_OFF_ENABLE: ahbOut.hrdata <= {31'h0, block_enable_reg};
				`SMTC_OFF_CTRL: ahbOut.hrdata <= {16'h0, main_control_reg};
				`SMTC_OFF_FRAMES: ahbOut.hrdata <= {16'h0, frame_count_reg};
				`SMTC_OFF_THREEW: ahbOut.hrdata <= {29'h0, three_wire_control_reg};
				`SMTC_OFF_TARGET: ahbOut.hrdata <= {28'h0, target_enable_reg};
				`SMTC_OFF_DIV: ahbOut.hrdata <= {16'h0, clock_divider_reg};
				`SMTC_OFF_TXTHR: ahbOut.hrdata <= {29'h0, tx_threshold_level};
				`SMTC_OFF_RXTHR: ahbOut.hrdata <= {29'h0, rx_threshold_level};
				`SMTC_OFF_TXDMA: ahbOut.hrdata <= {29'h0, tx_dma_level};
				`SMTC_OFF_RXDMA: ahbOut.hrdata <= {29'h0, rx_dma_level};
				`SMTC_OFF_DMACTL: ahbOut.hrdata <= {30'h0, dmaCtl_reg};
				// RULE2 busy in status
				`SMTC_OFF_STATUS: ahbOut.hrdata <= {25'h0, rxfLvl, txeLvl,
					rxCount_reg == `SMTC_FIFO_FULL, rxCount_reg != 4'h0,
					tx_fifo_empty_flag, txCount_reg != `SMTC_FIFO_FULL, busy_reg};
				`SMTC_OFF_TXLVL: ahbOut.hrdata <= {28'h0, txCount_reg};
				`SMTC_OFF_RXLVL: ahbOut.hrdata <= {28'h0, rxCount_reg};
				`SMTC_OFF_FIFO: ahbOut.hrdata <= busRdFifo ?
					{24'h0, rxMem[rxRd_reg]} : 32'h0;
				default: ahbOut.hrdata <= 32'h0;
				endcase
			end
		end
	end

	// Control, frame count, three-wire and divider registers are frozen while enabled, so a live transfer
	// never sees its mode or rate change underneath it.
	always_ff @(posedge clock) begin
		if (srst) begin
			block_enable_reg <= 1'b0;
			main_control_reg <= `SMTC_RST_CTRL;
			frame_count_reg <= `SMTC_RST_FRAMES;
			three_wire_control_reg <= 3'h0;
			target_enable_reg <= 4'h0;
			clock_divider_reg <= `SMTC_RST_DIV;
			tx_threshold_level <= 3'h0;
			rx_threshold_level <= 3'h0;
			tx_dma_level <= 3'h0;
			rx_dma_level <= 3'h0;
			dmaCtl_reg <= 2'h0;
		end else if (ce && dWr_reg) begin
			case (dAddr_reg)
			`SMTC_OFF_ENABLE: block_enable_reg <= ahbIn.hwdata[0];
			`SMTC_OFF_TARGET: target_enable_reg <= ahbIn.hwdata[3:0];
			`SMTC_OFF_TXTHR: tx_threshold_level <= ahbIn.hwdata[2:0];
			`SMTC_OFF_RXTHR: rx_threshold_level <= ahbIn.hwdata[2:0];
			`SMTC_OFF_TXDMA: tx_dma_level <= ahbIn.hwdata[2:0];
			`SMTC_OFF_RXDMA: rx_dma_level <= ahbIn.hwdata[2:0];
			`SMTC_OFF_DMACTL: dmaCtl_reg <= ahbIn.hwdata[1:0];
			default: ;
			endcase
			if (!block_enable_reg[0]) begin
				case (dAddr_reg)
				`SMTC_OFF_CTRL: main_control_reg <= ahbIn.hwdata[15:0];
				`SMTC_OFF_FRAMES: frame_count_reg <= ahbIn.hwdata[15:0];
				`SMTC_OFF_THREEW: three_wire_control_reg <= ahbIn.hwdata[2:0];
				`SMTC_OFF_DIV: clock_divider_reg <= ahbIn.hwdata[15:0];
				default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// FIFOs, flushed while the block is disabled
	always_ff @(posedge clock) begin
		if (srst || (ce && !block_enable_reg[0])) begin
			txWr_reg <= 3'h0;
			txRd_reg <= 3'h0;
			txCount_reg <= 4'h0;
		end else if (ce) begin
			if (busWrFifo) begin
				txMem[txWr_reg] <= ahbIn.hwdata[7:0];
				txWr_reg <= txWr_reg + 3'h1;
			end
			if (txPop_reg)
				txRd_reg <= txRd_reg + 3'h1;
			txCount_reg <= txCount_reg + {3'h0, busWrFifo} -
				{3'h0, txPop_reg};
		end
	end

	// Overflowing receive data is dropped, not overwritten.
	always_ff @(posedge clock) begin
		if (srst || (ce && !block_enable_reg[0])) begin
			rxWr_reg <= 3'h0;
			rxRd_reg <= 3'h0;
			rxCount_reg <= 4'h0;
		end else if (ce) begin
			if (rxPush_reg && rxCount_reg != `SMTC_FIFO_FULL) begin
				rxMem[rxWr_reg] <= rxData_reg;
				rxWr_reg <= rxWr_reg + 3'h1;
			end
			if (busRdFifo)
				rxRd_reg <= rxRd_reg + 3'h1;
			rxCount_reg <= rxCount_reg +
				{3'h0, rxPush_reg && rxCount_reg != `SMTC_FIFO_FULL} -
				{3'h0, busRdFifo};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive pin synchroniser and baud tick
	always_ff @(posedge clock) begin
		if (srst) begin
			rxdMeta_reg <= 1'b0;
			rxdSync_reg <= 1'b0;
		end else if (ce) begin
			rxdMeta_reg <= rxdPin;
			rxdSync_reg <= rxdMeta_reg;
		end
	end

	// One tick per half serial period; a divider below two stops the clock.
	assign tick = clock_divider_reg >= `SMTC_DIV_MIN &&
		divCnt_reg == clock_divider_reg[15:1] - 15'h1;

	always_ff @(posedge clock) begin
		if (srst || (ce && !block_enable_reg[0]))
			divCnt_reg <= 15'h0;
		else if (ce)
			divCnt_reg <= tick ? 15'h0 : divCnt_reg + 15'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// What follows the frame now ending
	always_comb begin
		goPop = 1'b0;
		goConst = 1'b0;
		capture = 1'b0;
		if (fmt == FMT_MW) begin
			// RULE23 direction meaning
			capture = mwInData_reg && !mwDir;
			if (!mwInData_reg) begin
				goPop = mwDir && txLeft;
				goConst = !mwDir;
			// RULE21 sequential count
			end else if (!mwDir && mwSeq) begin
				goConst = !rxHit;
			// RULE19 RULE20 end on empty
			end else begin
				goPop = txLeft;
			end
		end else begin
			case (kind)
			// RULE10 receive count
			KIND_RXONLY: begin
				capture = 1'b1;
				goConst = !rxHit;
			end
			// RULE11 command then reads
			KIND_EEPROM: begin
				capture = eeRx_reg;
				goPop = !eeRx_reg && txLeft;
				goConst = eeRx_reg ? !rxHit : !txLeft;
			end
			// RULE5 end on empty
			default: begin
				capture = kind == KIND_TXRX;
				goPop = txLeft;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift engine
	always_ff @(posedge clock) begin
		if (srst || (ce && !block_enable_reg[0])) begin
			state_reg <= ST_IDLE;
			shiftTx_reg <= 8'h00;
			shiftRx_reg <= 8'h00;
			rxData_reg <= 8'h00;
			bitCnt_reg <= 3'h0;
			half_reg <= 1'b0;
			mwInData_reg <= 1'b0;
			eeRx_reg <= 1'b0;
			hsWait_reg <= 1'b0;
			pendPop_reg <= 1'b0;
			pendConst_reg <= 1'b0;
			txPop_reg <= 1'b0;
			rxPush_reg <= 1'b0;
			rxCnt_reg <= 16'h0;
		end else if (ce) begin
			txPop_reg <= 1'b0;
			rxPush_reg <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				// RULE1 RULE3 RULE15 RULE18 start on edge
				if (tick && txLeft && target_enable_reg != 4'h0) begin
					state_reg <= ST_SHIFT;
					txPop_reg <= 1'b1;
					// RULE9 dummy word discarded
					shiftTx_reg <= (fmt != FMT_MW && kind == KIND_RXONLY) ?
						8'h00 : txMem[txRd_reg];
					bitCnt_reg <= 3'h0;
					half_reg <= 1'b0;
					mwInData_reg <= 1'b0;
					eeRx_reg <= 1'b0;
					rxCnt_reg <= 16'h0;
				end
			end
			ST_SHIFT: begin
				if (tick && !half_reg) begin
					half_reg <= 1'b1;
					shiftRx_reg <= {shiftRx_reg[6:0], rxdSync_reg};
				end else if (tick) begin
					half_reg <= 1'b0;
					shiftTx_reg <= {shiftTx_reg[6:0], 1'b0};
					bitCnt_reg <= bitCnt_reg + 3'h1;
					if (bitCnt_reg == 3'h7) begin
						if (capture) begin
							rxPush_reg <= 1'b1;
							rxData_reg <= shiftRx_reg;
							rxCnt_reg <= rxCnt_reg + 16'h1;
						end
						mwInData_reg <= fmt == FMT_MW &&
							(!mwInData_reg || (mwSeq && !mwDir));
						eeRx_reg <= eeRx_reg || (kind == KIND_EEPROM && !txLeft);
						pendPop_reg <= goPop;
						pendConst_reg <= goConst;
						hsWait_reg <= fmt == FMT_MW && handshake_enable_bit && mwInData_reg;
						state_reg <= ST_GAP;
					end
				end
			end
			ST_GAP: begin
				// RULE22 hold for ready
				if (!hsWait_reg || (tick && rxdSync_reg)) begin
					hsWait_reg <= 1'b0;
					txPop_reg <= pendPop_reg;
					shiftTx_reg <= pendPop_reg ? txMem[txRd_reg] : 8'h00;
					state_reg <= (pendPop_reg || pendConst_reg) ?
						ST_SHIFT : ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins, busy and requests, all registered
	always_ff @(posedge clock) begin
		if (srst) begin
			serOut <= '{sclk: 1'b0, ssN: 4'hf, txd: 1'b0};
			busy_reg <= 1'b0;
			reqOut <= '0;
		end else if (ce) begin
			serOut.sclk <= cpol ^ half_reg;
			serOut.txd <= shiftTx_reg[7];
			// SSP frame pulse during the first bit; others active low
			if (fmt == FMT_SSP)
				serOut.ssN <= (state_reg == ST_SHIFT && bitCnt_reg == 3'h0) ?
					target_enable_reg : 4'h0;
			else
				serOut.ssN <= (state_reg == ST_IDLE) ? 4'hf : ~target_enable_reg;
			// RULE2 RULE3 busy while shifting
			busy_reg <= state_reg != ST_IDLE;
			// RULE6 early empty
			reqOut.txEmpty <= block_enable_reg[0] && txeLvl;
			// RULE7 tx DMA level
			reqOut.txDma <= dmaCtl_reg[`SMTC_DMA_TX_BIT] &&
				block_enable_reg[0] && txCount_reg <= {1'b0, tx_dma_level};
			// RULE13 rx threshold and DMA
			reqOut.rxFull <= rxfLvl;
			reqOut.rxDma <= dmaCtl_reg[`SMTC_DMA_RX_BIT] &&
				rxCount_reg > {1'b0, rx_dma_level};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// RULE1 start conditions
	a_start_cond: assert property (@(posedge clock) disable iff (srst)
		ce && state_reg == ST_IDLE && !(txLeft && target_enable_reg != 4'h0)
		|=> state_reg == ST_IDLE) else $error("start without data or target");
	// RULE3 start waits for edge
	a_busy_edge: assert property (@(posedge clock) disable iff (srst)
		state_reg == ST_IDLE && !tick |=> state_reg == ST_IDLE)
		else $error("shift began off the baud edge");
	// RULE2 busy tracks engine
	a_busy_flag: assert property (@(posedge clock) disable iff (srst)
		ce && $rose(state_reg != ST_IDLE) |=> busy_reg)
		else $error("busy missing while shifting");
	// RULE5 end on empty
	a_tx_end: assert property (@(posedge clock) disable iff (srst)
		ce && state_reg == ST_GAP && !pendPop_reg && !pendConst_reg &&
		!hsWait_reg |=> state_reg == ST_IDLE) else $error("transfer ran on");
	// RULE9 txd constant
	a_rxonly_txd: assert property (@(posedge clock) disable iff (srst)
		ce && fmt != FMT_MW && kind == KIND_RXONLY && state_reg != ST_IDLE
		|=> !serOut.txd) else $error("txd moved in receive only");
	// RULE10 count ends transfer
	a_rx_count: assert property (@(posedge clock) disable iff (srst)
		ce && state_reg == ST_SHIFT && tick && half_reg &&
		bitCnt_reg == 3'h7 && fmt != FMT_MW && kind == KIND_RXONLY && rxHit
		|=> !pendConst_reg ##1 1'b1) else $error("receive count missed");
	// RULE6 early empty
	a_txe_level: assert property (@(posedge clock) disable iff (srst)
		ce && block_enable_reg[0] |=> reqOut.txEmpty == $past(txeLvl))
		else $error("early empty wrong");
	// RULE7 tx DMA level
	a_tx_dma: assert property (@(posedge clock) disable iff (srst)
		ce && !dmaCtl_reg[`SMTC_DMA_TX_BIT] |=> !reqOut.txDma)
		else $error("tx DMA without enable");
	// RULE13 rx threshold
	a_rx_level: assert property (@(posedge clock) disable iff (srst)
		ce |=> reqOut.rxFull == $past(rxCount_reg > {1'b0, rx_threshold_level}))
		else $error("rx threshold flag wrong");
	// RULE22 hold for ready
	a_hs_hold: assert property (@(posedge clock) disable iff (srst)
		ce && block_enable_reg[0] && state_reg == ST_GAP && hsWait_reg &&
		!rxdSync_reg |=> state_reg == ST_GAP) else $error("handshake skipped");
endmodule // smtc_core
`default_nettype wire

// *** core/smtc_pkg.sv ***
// Types shared by the serial master transfer control.
// Assumes a single AHB-Lite slave port and four select lines.
`default_nettype none
package smtc_pkg;
	typedef enum logic [1:0] {KIND_TXRX = 2'b00, KIND_TXONLY = 2'b01,
		KIND_RXONLY = 2'b10, KIND_EEPROM = 2'b11} smtc_kind_t;
	typedef enum logic [1:0] {FMT_SPI = 2'b00, FMT_SSP = 2'b01,
		FMT_MW = 2'b10, FMT_RSVD = 2'b11} smtc_fmt_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SHIFT = 2'b01,
		ST_GAP = 2'b10, ST_SPARE = 2'b11} smtc_state_t;
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} smtc_ahb_in_t;
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} smtc_ahb_out_t;
	typedef struct packed {
		logic sclk;
		logic [3:0] ssN;
		logic txd;
	} smtc_ser_t;
	typedef struct packed {
		logic txDma;
		logic rxDma;
		logic txEmpty;
		logic rxFull;
	} smtc_req_t;
endpackage
`default_nettype wire

// *** core/smtc_regs.svh ***
// Register offsets, field positions and reset values of the serial master.
// Assumes AHB-Lite byte addresses with one 32-bit word per register.
`ifndef SMTC_REGS_SVH
`define SMTC_REGS_SVH
`define SMTC_OFF_ENABLE 8'h00
`define SMTC_OFF_CTRL 8'h04
`define SMTC_OFF_FRAMES 8'h08
`define SMTC_OFF_THREEW 8'h0c
`define SMTC_OFF_TARGET 8'h10
`define SMTC_OFF_DIV 8'h14
`define SMTC_OFF_TXTHR 8'h18
`define SMTC_OFF_RXTHR 8'h1c
`define SMTC_OFF_TXDMA 8'h20
`define SMTC_OFF_RXDMA 8'h24
`define SMTC_OFF_DMACTL 8'h28
`define SMTC_OFF_STATUS 8'h2c
`define SMTC_OFF_TXLVL 8'h30
`define SMTC_OFF_RXLVL 8'h34
`define SMTC_OFF_FIFO 8'h38
`define SMTC_CTL_FMT_LSB 4
`define SMTC_CTL_CPOL_BIT 7
`define SMTC_CTL_KIND_LSB 8
`define SMTC_MW_SEQ_BIT 0
`define SMTC_MW_DIR_BIT 1
`define SMTC_MW_HS_BIT 2
`define SMTC_DMA_RX_BIT 0
`define SMTC_DMA_TX_BIT 1
`define SMTC_ST_BUSY_BIT 0
`define SMTC_ST_TNF_BIT 1
`define SMTC_ST_TFE_BIT 2
`define SMTC_ST_RNE_BIT 3
`define SMTC_ST_RFF_BIT 4
`define SMTC_ST_TXE_BIT 5
`define SMTC_ST_RXF_BIT 6
`define SMTC_RST_CTRL 16'h0000
`define SMTC_RST_DIV 16'h0000
`define SMTC_RST_FRAMES 16'h0000
`define SMTC_DIV_MIN 16'h0002
`define SMTC_FIFO_FULL 4'h8
`endif

// *** tb/smtc_slave_model.sv ***
// Behavioural serial target: returns a fixed reply, captures what it gets.
// Assumes clock polarity zero and active-low selects from the master.
`timescale 1ns/1ps
`default_nettype none
module smtc_slave_model (
	input wire logic clock,
	input wire smtc_pkg::smtc_ser_t serIn,
	input wire logic [7:0] reply,
	output logic rxd,
	output logic [7:0] gotByte,
	output int gotCount
);
	import smtc_pkg::*;
	logic selD = 1'b0;
	logic sclkD = 1'b0;
	logic [7:0] txShift = 8'h00;
	logic [7:0] rxShift = 8'h00;
	int n = 0;
	initial begin
		rxd = 1'b0;
		gotByte = 8'h00;
		gotCount = 0;
	end
	////////////////////////////////////////////////////////////////////////
	// target sampling on rise
	// Falling core edge keeps clear of the master's own updates
	always @(negedge clock) begin
		if (serIn.ssN == 4'hf) begin
			// Released line must not show a stale bit
			rxd <= ~rxd;
		end else if (selD == 1'b0) begin
			n = 0;
			txShift = reply;
			rxd <= reply[7];
		end else if (serIn.sclk && !sclkD) begin
			rxShift = {rxShift[6:0], serIn.txd};
			n = n + 1;
			if (n == 8) begin
				gotByte = rxShift;
				gotCount = gotCount + 1;
				n = 0;
			end
		end else if (!serIn.sclk && sclkD) begin
			txShift = (n == 0) ? reply : {txShift[6:0], 1'b0};
			rxd <= txShift[7];
		end
		selD = (serIn.ssN != 4'hf);
		sclkD = serIn.sclk;
	end
endmodule // smtc_slave_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the serial master transfer control.
// Assumes the behavioural serial target and one AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "smtc_regs.svh"
module tb;
	import smtc_pkg::*;
	typedef struct {
		logic [1:0] fmt;
		logic [1:0] kind;
		logic [2:0] mw;
		int ntx;
		logic [15:0] frames;
		int nSer;
		int nRx;
		logic [7:0] last;
	} smtc_row_t;
	localparam logic [31:0] DIVV = 32'h0000_0008;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	smtc_ahb_in_t mst = '0;
	smtc_ahb_in_t ahbBus;
	smtc_ahb_out_t ahbOut;
	smtc_ser_t serOut;
	smtc_req_t reqOut;
	logic rxd;
	logic [7:0] gotByte;
	int gotCount;
	int num_errors = 0;
	int checks = 0;
	// Kind rows: tx/rx, tx only, rx only, eeprom, three-wire transmit,
	// eeprom under SSP, three-wire receive with handshake, sequential
	smtc_row_t rows [8] = '{
		'{2'b00, 2'b00, 3'h0, 2, 16'h0000, 2, 2, 8'h11},
		'{2'b00, 2'b01, 3'h0, 3, 16'h0000, 3, 0, 8'h12},
		'{2'b00, 2'b10, 3'h0, 1, 16'h0002, 3, 3, 8'h00},
		'{2'b00, 2'b11, 3'h0, 2, 16'h0001, 4, 2, 8'h00},
		'{2'b10, 2'b00, 3'h2, 2, 16'h0000, 2, 0, 8'h11},
		'{2'b01, 2'b11, 3'h0, 2, 16'h0000, 2, 2, 8'h11},
		'{2'b10, 2'b00, 3'h4, 1, 16'h0000, 2, 1, 8'h00},
		'{2'b10, 2'b00, 3'h1, 1, 16'h0001, 3, 2, 8'h00}
	};
	assign ahbBus = {mst[$bits(smtc_ahb_in_t)-1:1], ahbOut.hreadyout};
	always #12.5 clock = ~clock;
	smtc_core smtc_core_i (.clock(clock), .srst(srst), .ce(ce),
		.ahbIn(ahbBus), .ahbOut(ahbOut), .rxdPin(rxd), .serOut(serOut),
		.reqOut(reqOut));
	smtc_slave_model smtc_slave_model_i (.clock(clock), .serIn(serOut),
		.reply(8'h96), .rxd(rxd), .gotByte(gotByte), .gotCount(gotCount));
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	// Single word transfer; waits on hready, never on a fixed count
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rdv);
		int n;
		n = 0;
		@(posedge clock);
		mst.hsel <= 1'b1;
		mst.haddr <= {24'h000000, a};
		mst.htrans <= 2'b10;
		mst.hwrite <= w;
		mst.hsize <= 3'b010;
		do begin
			@(posedge clock);
			n++;
		end while (ahbOut.hreadyout !== 1'b1 && n < 50);
		mst.htrans <= 2'b00;
		mst.hwdata <= wd;
		do begin
			@(posedge clock);
			n++;
		end while (ahbOut.hreadyout !== 1'b1 && n < 50);
		rdv = ahbOut.hrdata;
		if (n >= 50) begin
			num_errors++;
			$display("wrong value at %0t: bus stalled", $time);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		xfer(1'b1, a, d, unused);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h0, d);
	endtask
	task automatic waitDone();
		logic [31:0] st;
		int n;
		n = 0;
		repeat (2 * DIVV) @(posedge clock);
		rd(`SMTC_OFF_STATUS, st);
		check(32'(st[0]), 32'h1);
		while (st[0] !== 1'b0 && n < 400) begin
			rd(`SMTC_OFF_STATUS, st);
			n++;
		end
		check(32'(st[0]), 32'h0);
	endtask
	task automatic setup(input logic [31:0] ctl, input logic [31:0] div);
		wr(`SMTC_OFF_ENABLE, 32'h0);
		wr(`SMTC_OFF_TARGET, 32'h0);
		wr(`SMTC_OFF_CTRL, ctl);
		wr(`SMTC_OFF_DIV, div);
	endtask
	task automatic runRow(input smtc_row_t r);
		logic [31:0] st;
		int base;
		base = gotCount;
		setup((32'(r.kind) << `SMTC_CTL_KIND_LSB) |
			(32'(r.fmt) << `SMTC_CTL_FMT_LSB), DIVV);
		wr(`SMTC_OFF_FRAMES, 32'(r.frames));
		wr(`SMTC_OFF_THREEW, 32'(r.mw));
		wr(`SMTC_OFF_ENABLE, 32'h1);
		for (int i = 0; i < r.ntx; i++) wr(`SMTC_OFF_FIFO, 32'h10 + i);
		rd(`SMTC_OFF_STATUS, st);
		check(32'(st[0]), 32'h0);
		rd(`SMTC_OFF_TXLVL, st);
		check(st, 32'(r.ntx));
		wr(`SMTC_OFF_TARGET, 32'h1);
		waitDone();
		check(32'(gotCount - base), 32'(r.nSer));
		check(32'(gotByte), 32'(r.last));
		rd(`SMTC_OFF_RXLVL, st);
		check(st, 32'(r.nRx));
		for (int i = 0; i < r.nRx; i++) begin
			rd(`SMTC_OFF_FIFO, st);
			check(st, 32'h96);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(posedge clock);
		num_errors++;
		conclude();
	end
	initial begin
		logic [31:0] st;
		int base;
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		check(32'(serOut), 32'h1e);
		check(32'(reqOut), 32'h0);
		rd(`SMTC_OFF_STATUS, st);
		check(st, 32'h26);
		rd(8'h40, st);
		check(st, 32'h0);
		foreach (rows[i]) runRow(rows[i]);
		// Requests against levels, then a full transmit FIFO
		setup(32'h0, DIVV);
		wr(`SMTC_OFF_TXTHR, 32'h2);
		wr(`SMTC_OFF_TXDMA, 32'h1);
		wr(`SMTC_OFF_RXTHR, 32'h1);
		wr(`SMTC_OFF_RXDMA, 32'h0);
		wr(`SMTC_OFF_DMACTL, 32'h3);
		wr(`SMTC_OFF_ENABLE, 32'h1);
		repeat (2) @(negedge clock);
		check(32'(reqOut), 32'ha);
		for (int i = 0; i < 9; i++) wr(`SMTC_OFF_FIFO, 32'h20 + i);
		rd(`SMTC_OFF_TXLVL, st);
		check(st, 32'h8);
		@(negedge clock);
		check(32'(reqOut), 32'h0);
		wr(`SMTC_OFF_TARGET, 32'h1);
		waitDone();
		repeat (2) @(negedge clock);
		check(32'(reqOut), 32'hf);
		wr(`SMTC_OFF_CTRL, 32'h100);
		rd(`SMTC_OFF_CTRL, st);
		check(st, 32'h0);
		wr(`SMTC_OFF_ENABLE, 32'h0);
		rd(`SMTC_OFF_RXLVL, st);
		check(st, 32'h0);
		// Divider below two: clock stopped, nothing may start
		base = gotCount;
		wr(`SMTC_OFF_DIV, 32'h1);
		wr(`SMTC_OFF_ENABLE, 32'h1);
		wr(`SMTC_OFF_FIFO, 32'h55);
		repeat (40) @(negedge clock);
		rd(`SMTC_OFF_STATUS, st);
		check(32'(st[0]), 32'h0);
		rd(`SMTC_OFF_TXLVL, st);
		check(st, 32'h1);
		check(32'(gotCount - base), 32'h0);
		wr(`SMTC_OFF_ENABLE, 32'h0);
		conclude();
	end
endmodule // tb
`default_nettype wire
